// File: src/sysint_pkg.sv
/*
 * constants of the system integration register bank: addresses,
 * field positions and reset values.
 * assumes one byte-addressed 32-bit register port on the bus clock.
 */
package sysint_pkg;

    localparam logic [31:0] ADDR_CAUSE_ID  = 32'h4004_8000;
    localparam logic [31:0] ADDR_OPTIONS   = 32'h4004_8004;
    localparam logic [31:0] ADDR_PIN_SEL   = 32'h4004_8008;
    localparam logic [31:0] ADDR_CLK_GATE  = 32'h4004_800C;
    localparam logic [31:0] ADDR_UID_LOW   = 32'h4004_8010;
    localparam logic [31:0] ADDR_UID_HIGH  = 32'h4004_8014;
    localparam logic [31:0] ADDR_BUS_DIV   = 32'h4004_8018;
    localparam logic [31:0] ADDR_EVT_STAT  = 32'h4004_801C;
    localparam logic [31:0] ADDR_EVT_MASK  = 32'h4004_8020;

    localparam logic [31:0] RST_OPTIONS    = 32'h0000_0000;
    localparam logic [31:0] RST_PIN_SEL    = 32'h0000_0000;
    localparam logic [31:0] RST_CLK_GATE   = 32'h0000_3000;
    localparam logic [31:0] RST_BUS_DIV    = 32'h0000_0000;
    localparam logic [31:0] RST_EVT_MASK   = 32'h0000_0000;

    // identity field positions
    localparam int FAMILY_POS     = 28;
    localparam int SUBFAMILY_POS  = 24;
    localparam int REVISION_POS   = 20;
    localparam int PKG_SIZE_POS   = 16;

    // arbitrary neutral identity values
    localparam logic [3:0] FAMILY_DEFAULT    = 4'h5;
    localparam logic [3:0] SUBFAMILY_DEFAULT = 4'h3;
    localparam logic [3:0] REVISION_DEFAULT  = 4'h1;
    localparam logic [3:0] PKG_64_PIN        = 4'h7;
    localparam logic [3:0] PKG_100_PIN       = 4'hA;

    // reset cause flag positions
    localparam int STOP_ERR_BIT   = 13;
    localparam int DEBUG_RST_BIT  = 11;
    localparam int SOFT_RST_BIT   = 10;
    localparam int HANG_BIT       = 9;
    localparam int POWER_ON_BIT   = 7;
    localparam int PIN_RST_BIT    = 6;
    localparam int WATCHDOG_BIT   = 5;
    localparam int OSC_RST_BIT    = 2;
    localparam int LOW_SUPPLY_BIT = 1;
    localparam logic [31:0] CAUSE_MASK = 32'h0000_2EE6;

endpackage : sysint_pkg

// File: src/level_sync.sv
/*
 * two-flop synchroniser for a vector of slow levels.
 * assumes each bit is quasi-static; no bus coherency is promised.
 */
`timescale 1ns/1ps
module level_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             core_clk,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk)
    begin
        stage_one <= async_in;
        sync_out  <= stage_one;
    end

endmodule : level_sync

// File: src/cause_latch.sv
/*
 * collects reset causes while reset is held and latches them into
 * the cause flags on the first clock after release, keeping only power-on and low supply when power-on is among them.
 * assumes the reset controller holds each cause level through reset.
 */
`timescale 1ns/1ps
module cause_latch
    import sysint_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] cause_now,
    output logic      [31:0] cause_flags,
    output logic             capture_pulse
);

    logic [31:0] gathered;
    logic        released;

    // accumulate causes during reset, drop them once taken
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            gathered <= gathered | (cause_now & CAUSE_MASK);
        else if (capture_pulse)
            gathered <= 32'h0000_0000;
    end

    // marks the first cycle after release
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            released <= 1'b0;
        else
            released <= 1'b1;
    end

    assign capture_pulse = resetn && !released;

    // flags hold the latest reset's causes until the next one
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            cause_flags <= 32'h0000_0000;
        else if (capture_pulse)
        begin
            if (gathered[POWER_ON_BIT])
                cause_flags <= gathered &
                    ((32'h1 << POWER_ON_BIT) | (32'h1 << LOW_SUPPLY_BIT));
            else
                cause_flags <= gathered;
        end
    end

endmodule : cause_latch

// File: src/system_reset_status_id_bank.sv
/*
 * system integration register bank: reset cause and identity,
 * options, pin selection, clock gating, unique id and bus divider,
 * plus a reset-cause event status and mask with one interrupt.
 * assumes a single-cycle strobe master on core_clk; cause and id
 * inputs come from other domains and are synchronised here.
 */
`timescale 1ns/1ps
module system_reset_status_id_bank
    import sysint_pkg::*;
#(
    parameter logic [3:0]  FAMILY_CODE   = FAMILY_DEFAULT,
    parameter logic [3:0]  SUBFAMILY     = SUBFAMILY_DEFAULT,
    parameter logic [3:0]  REVISION      = REVISION_DEFAULT,
    parameter logic [3:0]  PACKAGE_CODE  = PKG_64_PIN,
    parameter logic [31:0] OPTIONS_INIT  = RST_OPTIONS,
    parameter logic [31:0] BUS_DIV_INIT  = RST_BUS_DIV
)
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_write,
    input  wire logic        bus_read,
    output logic      [31:0] bus_rdata,
    input  wire logic        stop_handshake_error_reset,
    input  wire logic        debugger_reset_request,
    input  wire logic        core_reset_request_bit,
    input  wire logic        core_hang_reset,
    input  wire logic        power_on_reset,
    input  wire logic        reset_pin_low,
    input  wire logic        watchdog_timeout,
    input  wire logic        watchdog_enabled,
    input  wire logic        oscillator_module_reset,
    input  wire logic        low_supply_reset,
    input  wire logic [31:0] unique_id_low_in,
    input  wire logic [31:0] unique_id_high_in,
    output logic      [31:0] system_options,
    output logic      [31:0] pin_selection,
    output logic      [31:0] clock_gating_control,
    output logic      [31:0] bus_clock_divider,
    output logic             irq
);

    // synchronised copies of the cause levels
    logic [9:0]  cause_raw;
    logic [9:0]  cause_sync;
    logic [63:0] uid_sync;
    logic [31:0] cause_now;
    logic [31:0] cause_flags;
    logic        capture_pulse;
    logic        capture_seen;

    // register selects
    logic        sel_cause_id;
    logic        sel_options;
    logic        sel_pin_sel;
    logic        sel_clk_gate;
    logic        sel_uid_low;
    logic        sel_uid_high;
    logic        sel_bus_div;
    logic        sel_evt_stat;
    logic        sel_evt_mask;

    // event logic
    logic [31:0] event_status;
    logic [31:0] event_mask;
    logic [31:0] next_event_status;
    logic [31:0] identity_word;
    logic [31:0] read_mux;

    // gather the cause pins into one vector for synchronising
    assign cause_raw = {
        stop_handshake_error_reset,
        debugger_reset_request,
        core_reset_request_bit,
        core_hang_reset,
        power_on_reset,
        reset_pin_low,
        watchdog_timeout,
        watchdog_enabled,
        oscillator_module_reset,
        low_supply_reset
    };

    // cause levels cross from the reset controller's domain
    level_sync
    #(
        .WIDTH (10)
    )
    u_cause_sync
    (
        .core_clk (core_clk),
        .async_in (cause_raw),
        .sync_out (cause_sync)
    );

    // unique id comes from fuses outside the bus clock domain
    level_sync
    #(
        .WIDTH (64)
    )
    u_uid_sync
    (
        .core_clk (core_clk),
        .async_in ({unique_id_high_in, unique_id_low_in}),
        .sync_out (uid_sync)
    );

    // place each synchronised cause at its flag position
    always_comb
    begin
        cause_now                 = 32'h0000_0000;
        cause_now[STOP_ERR_BIT]   = cause_sync[9];
        cause_now[DEBUG_RST_BIT]  = cause_sync[8];
        cause_now[SOFT_RST_BIT]   = cause_sync[7];
        cause_now[HANG_BIT]       = cause_sync[6];
        cause_now[POWER_ON_BIT]   = cause_sync[5];
        cause_now[PIN_RST_BIT]    = cause_sync[4];
        // a disabled watchdog cannot cause a reset
        cause_now[WATCHDOG_BIT]   = cause_sync[3]
                                    && cause_sync[2];
        cause_now[OSC_RST_BIT]    = cause_sync[1];
        // power-on also marks the low supply flag
        cause_now[LOW_SUPPLY_BIT] = cause_sync[0]
                                    || cause_sync[5];
    end

    // latches the causes when reset is released
    cause_latch u_cause_latch
    (
        .core_clk      (core_clk),
        .resetn        (resetn),
        .cause_now     (cause_now),
        .cause_flags   (cause_flags),
        .capture_pulse (capture_pulse)
    );

    // full-address decode of the bank
    assign sel_cause_id = (bus_addr == ADDR_CAUSE_ID);
    assign sel_options  = (bus_addr == ADDR_OPTIONS);
    assign sel_pin_sel  = (bus_addr == ADDR_PIN_SEL);
    assign sel_clk_gate = (bus_addr == ADDR_CLK_GATE);
    assign sel_uid_low  = (bus_addr == ADDR_UID_LOW);
    assign sel_uid_high = (bus_addr == ADDR_UID_HIGH);
    assign sel_bus_div  = (bus_addr == ADDR_BUS_DIV);
    assign sel_evt_stat = (bus_addr == ADDR_EVT_STAT);
    assign sel_evt_mask = (bus_addr == ADDR_EVT_MASK);

    // identity word: hard-wired codes over the latched cause flags
    always_comb
    begin
        identity_word = cause_flags & CAUSE_MASK;
        identity_word[FAMILY_POS+:4]    = FAMILY_CODE;
        identity_word[SUBFAMILY_POS+:4] = SUBFAMILY;
        identity_word[REVISION_POS+:4]  = REVISION;
        identity_word[PKG_SIZE_POS+:4]  = PACKAGE_CODE;
    end

    // system options; field reset values come from the parameter
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            system_options <= OPTIONS_INIT;
        else if (bus_write && sel_options)
            system_options <= bus_wdata;
    end

    // pin selection clears on reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            pin_selection <= RST_PIN_SEL;
        else if (bus_write && sel_pin_sel)
            pin_selection <= bus_wdata;
    end

    // clock gating comes out of reset with two gates open
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            clock_gating_control <= RST_CLK_GATE;
        else if (bus_write && sel_clk_gate)
            clock_gating_control <= bus_wdata;
    end

    // bus clock divider setting
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            bus_clock_divider <= BUS_DIV_INIT;
        else if (bus_write && sel_bus_div)
            bus_clock_divider <= bus_wdata;
    end

    // event mask gates status onto the interrupt
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            event_mask <= RST_EVT_MASK;
        else if (bus_write && sel_evt_mask)
            event_mask <= bus_wdata & CAUSE_MASK;
    end

    // one cycle after capture, so the latched flags are settled
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            capture_seen <= 1'b0;
        else
            capture_seen <= capture_pulse;
    end

    // write one to clear; a capture in the same cycle wins
    always_comb
    begin
        next_event_status = event_status;
        if (bus_write && sel_evt_stat)
            next_event_status = next_event_status & ~bus_wdata;
        if (capture_seen)
            next_event_status = next_event_status
                                | (cause_flags & CAUSE_MASK);
    end

    // sticky event status mirrors the latched flags, not the live
    // cause pins, so late cause edges never reach the interrupt
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            event_status <= 32'h0000_0000;
        else
            event_status <= next_event_status & CAUSE_MASK;
    end

    // level interrupt while any unmasked event stands
    assign irq = |(event_status & event_mask);

    // read multiplexer; unmapped addresses read zero
    always_comb
    begin
        read_mux = 32'h0000_0000;
        unique case (1'b1)
            sel_cause_id: read_mux = identity_word;
            sel_options:  read_mux = system_options;
            sel_pin_sel:  read_mux = pin_selection;
            sel_clk_gate: read_mux = clock_gating_control;
            sel_uid_low:  read_mux = uid_sync[31:0];
            sel_uid_high: read_mux = uid_sync[63:32];
            sel_bus_div:  read_mux = bus_clock_divider;
            sel_evt_stat: read_mux = event_status;
            sel_evt_mask: read_mux = event_mask;
            default:      read_mux = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            bus_rdata <= 32'h0000_0000;
        else if (bus_read)
            bus_rdata <= read_mux;
        else
            bus_rdata <= 32'h0000_0000;
    end

endmodule : system_reset_status_id_bank

// File: tb/system_reset_status_id_bank_checker.sv
/* port checker for the register bank: bus answers, identity word,
   writable registers and the reset values of pin selection and clock gating.
   assumes one clock core_clk and synchronous active-low resetn. */
`timescale 1ns/1ps
module bank_checker
    import sysint_pkg::*;
#(
    parameter logic [3:0] FAMILY_CODE  = FAMILY_DEFAULT,
    parameter logic [3:0] SUBFAMILY    = SUBFAMILY_DEFAULT,
    parameter logic [3:0] REVISION     = REVISION_DEFAULT,
    parameter logic [3:0] PACKAGE_CODE = PKG_64_PIN
)
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [31:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_write,
    input  wire logic        bus_read,
    input  wire logic [31:0] bus_rdata,
    input  wire logic [31:0] system_options,
    input  wire logic [31:0] pin_selection,
    input  wire logic [31:0] clock_gating_control,
    input  wire logic [31:0] bus_clock_divider
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // read data only in the answer cycle
    AST_RDATA_IDLE: assert property (
        !$past(bus_read) |-> bus_rdata == 32'h0)
        else $error("read data outside answer cycle");
    // identity fields of the cause word
    AST_ID_FIELDS: assert property (
        $past(bus_read) && $past(resetn) && $past(bus_addr) == ADDR_CAUSE_ID
        |-> bus_rdata[31:16] ==
            {FAMILY_CODE, SUBFAMILY, REVISION, PACKAGE_CODE})
        else $error("identity field wrong");
    AST_RESERVED_ZERO: assert property (
        $past(bus_read) && $past(resetn) && $past(bus_addr) == ADDR_CAUSE_ID
        |-> bus_rdata[15:14] == 2'h0 && !bus_rdata[12] && !bus_rdata[8])
        else $error("reserved status bit set");
    // writes land at the strobe edge
    AST_PIN_WRITE: assert property (
        bus_write && bus_addr == ADDR_PIN_SEL
        |=> pin_selection == $past(bus_wdata))
        else $error("pin selection write lost");
    AST_GATE_WRITE: assert property (
        bus_write && bus_addr == ADDR_CLK_GATE
        |=> clock_gating_control == $past(bus_wdata))
        else $error("clock gating write lost");
    AST_DIV_WRITE: assert property (
        bus_write && bus_addr == ADDR_BUS_DIV
        |=> bus_clock_divider == $past(bus_wdata))
        else $error("divider write lost");
    AST_OPTIONS_HOLD: assert property (
        !(bus_write && bus_addr == ADDR_OPTIONS) |=> $stable(system_options))
        else $error("options changed without write");
    AST_RESET_VALUES: assert property (
        $rose(resetn) |-> pin_selection == 32'h0000_0000
            && clock_gating_control == 32'h0000_3000)
        else $error("reset value wrong");
endmodule : bank_checker

bind system_reset_status_id_bank bank_checker #(
    .FAMILY_CODE(FAMILY_CODE), .SUBFAMILY(SUBFAMILY),
    .REVISION(REVISION), .PACKAGE_CODE(PACKAGE_CODE)
) u_chk (
    .core_clk(core_clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .system_options(system_options),
    .pin_selection(pin_selection),
    .clock_gating_control(clock_gating_control),
    .bus_clock_divider(bus_clock_divider)
);

// File: tb/test_system_reset_status_id_bank.sv
/* self-checking bench for the register bank: bus tasks, reset
   causes, event status and interrupt.
   assumes the package identity defaults on the design. */
`timescale 1ns/1ps
module test_system_reset_status_id_bank;
    import sysint_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [31:0] bus_addr = 32'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_write = 1'b0;
    logic        bus_read = 1'b0;
    logic [8:0]  cause = 9'h0;
    logic        wd_en = 1'b1;
    logic [31:0] uid_lo = 32'h0;
    logic [31:0] uid_hi = 32'h0;
    logic [31:0] bus_rdata, opt, pin, gate, div, e;
    logic        irq;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          pos [9] = '{13, 11, 10, 9, 7, 6, 5, 2, 1};
    logic [31:0] rw_a [4] = '{ADDR_OPTIONS, ADDR_PIN_SEL, ADDR_CLK_GATE,
                              ADDR_BUS_DIV};
    logic [31:0] ro_a [4] = '{ADDR_CAUSE_ID, ADDR_UID_LOW, ADDR_UID_HIGH,
                              32'h4004_8024};
    logic [31:0] exp_rw [4] = '{RST_OPTIONS, 32'h0, 32'h3000, RST_BUS_DIV};

    always #2 core_clk = ~core_clk;

    system_reset_status_id_bank dut (
        .core_clk(core_clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .stop_handshake_error_reset(cause[0]),
        .debugger_reset_request(cause[1]), .core_reset_request_bit(cause[2]),
        .core_hang_reset(cause[3]), .power_on_reset(cause[4]),
        .reset_pin_low(cause[5]), .watchdog_timeout(cause[6]),
        .watchdog_enabled(wd_en), .oscillator_module_reset(cause[7]),
        .low_supply_reset(cause[8]), .unique_id_low_in(uid_lo),
        .unique_id_high_in(uid_hi), .system_options(opt),
        .pin_selection(pin), .clock_gating_control(gate),
        .bus_clock_divider(div), .irq(irq)
    );

    task automatic check(input string nm, input logic [31:0] x,
                         input logic [31:0] g);
        total_checks++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_write <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_write <= 1'b0;
        #1;
    endtask : wr

    task automatic rc(input logic [31:0] a, input logic [31:0] x,
                      input string nm);
        @(posedge core_clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_read <= 1'b0;
        #1 check(nm, x, bus_rdata);
    endtask : rc

    // causes settle through the two-flop sync before reset falls,
    // so levels left from the previous run are not gathered
    task automatic do_reset(input logic [8:0] c, input logic w);
        @(posedge core_clk);
        cause  <= c;
        wd_en  <= w;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b0;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
    endtask : do_reset

    // expected cause word for one cause index, identity included
    function automatic logic [31:0] exp_cause(input int i, input logic w);
        logic [31:0] f;
        f = {FAMILY_DEFAULT, SUBFAMILY_DEFAULT, REVISION_DEFAULT,
             PKG_64_PIN, 16'h0};
        if (i == 4)
            f[1] = 1'b1;
        if (i != 6 || w)
            f[pos[i]] = 1'b1;
        return f;
    endfunction : exp_cause

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // hang guard
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end

    initial
    begin
        int k;
        int idx;
        void'($urandom(95));
        uid_lo <= $urandom;
        uid_hi <= $urandom;
        // power-on reset, then reset values and identity
        do_reset(9'h010, 1'b1);
        rc(ADDR_CAUSE_ID, exp_cause(4, 1'b1), "cause");
        for (int j = 0; j < 4; j++)
            rc(rw_a[j], exp_rw[j], "reset_value");
        rc(ADDR_UID_LOW, uid_lo, "uid_low");
        rc(ADDR_UID_HIGH, uid_hi, "uid_high");
        // read-only and unmapped words drop writes
        for (int j = 0; j < 4; j++)
            wr(ro_a[j], 32'hFFFF_FFFF);
        rc(ADDR_CAUSE_ID, exp_cause(4, 1'b1), "cause_ro");
        rc(ADDR_UID_LOW, uid_lo, "uid_ro");
        rc(32'h4004_8024, 32'h0, "unmapped");
        // random writes to the writable words, read back
        for (int n = 0; n < 24; n++)
        begin
            k = $urandom_range(3);
            exp_rw[k] = $urandom;
            wr(rw_a[k], exp_rw[k]);
            rc(rw_a[k], exp_rw[k], "rw_word");
        end
        check("opt_port", exp_rw[0], opt);
        check("pin_port", exp_rw[1], pin);
        check("gate_port", exp_rw[2], gate);
        check("div_port", exp_rw[3], div);
        // each cause alone, last pass a watchdog while disabled
        for (int i = 0; i < 10; i++)
        begin
            idx = (i == 9) ? 6 : i;
            do_reset(9'h1 << idx, i != 9);
            e = exp_cause(idx, i != 9);
            rc(ADDR_CAUSE_ID, e, "cause_flag");
            cause <= 9'h1FF;
            rc(ADDR_CAUSE_ID, e, "cause_held");
            rc(ADDR_EVT_STAT, e & CAUSE_MASK, "event_status");
            check("irq_masked", 32'h0, {31'h0, irq});
            wr(ADDR_EVT_MASK, 32'hFFFF_FFFF);
            check("irq_set", {31'h0, (e & CAUSE_MASK) != 0},
                  {31'h0, irq});
            wr(ADDR_EVT_STAT, 32'hFFFF_FFFF);
            check("irq_clear", 32'h0, {31'h0, irq});
            rc(ADDR_EVT_STAT, 32'h0, "status_clear");
        end
        results();
    end
endmodule : test_system_reset_status_id_bank
